// ---- i2cui_dev.sv ----
// device end: i2c user command interpreter with power control
// Functional notes
// - read start address must be readable, else nack
// - unreadable registers inside block read return zero
// - bytes past address range read as zero
// - address steps by one per data byte
// - master reads via repeated start and read address
// - master nacks last read byte, then stop
// - write start address must be writable, else nack
// - data to non-writable registers dropped, still acked
// - writes past range end are nacked
// - master writes without repeated start, ends stop
// - reload copies stored settings to working registers
// - program stores working registers, busy for time
// - enable pin low loses state, rise rebuilds
// - virtual disable keeps register state alive
// - enable pin stays high during virtual enabling
// - power byte: zero, test, mem, cal, restart, enable
// - enable one from disabled starts power-up
// - enable zero while operating enters disabled
// - restart with enable zero toggles straight through
// - calibration bit redoes calibration, else skipped once calibrated
// - memory bit reloads stored settings on power-up
// - test bit clears test registers on power-up
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module i2cui_dev #(
	parameter int unsigned PROG_CYC = i2cui_pkg::prog_cyc,
	parameter int unsigned CAL_CYC = i2cui_pkg::cal_cyc
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// link
	i2cui_if.dev bus,
	// user side
	input wire logic en_pin,
	input wire logic test_wr,
	input wire logic [7:0] test_wdata,
	input wire logic [3:0] user_raddr,
	output logic [7:0] user_rdata,
	output logic [7:0] test_reg,
	output logic operating,
	output logic cal_valid,
	output logic busy
);
	import i2cui_pkg::*;

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		i2cui_dst_t st;
		logic [3:0] cnt;
		logic phase;
		logic ack;
		logic [1:0] bidx;
		logic [7:0] sh;
		logic [7:0] tx;
		logic [7:0] cmd;
		logic rw;
		logic [4:0] ptr;
		logic wr_go;
		logic rd_go;
		logic oe_n;
		i2cui_pw_t pw;
		logic prog;
		logic [31:0] tmr;
		logic [31:0] ctmr;
		logic cal_valid;
		logic [7:0] test_reg;
		logic [7:0] rdata;
		logic [15:0][7:0] work;
		logic [15:0][7:0] nvm;
	} i2cui_dev_t;

	i2cui_dev_t r;
	i2cui_dev_t next_r;
	logic scl_rise;
	logic scl_fall;
	logic sda_in;
	logic start_seen;
	logic stop_seen;
	logic [7:0] rx_byte;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] rd_byte(input logic [15:0][7:0] w,
		input logic [4:0] p);
		if (p[4] || !rd_mask[p[3:0]])
		begin
			rd_byte = 8'h00;
		end
		else
		begin
			rd_byte = w[p[3:0]];
		end
	endfunction

	function automatic i2cui_dev_t power_up(input i2cui_dev_t d,
		input logic [7:0] set);
		power_up = d;
		if (set[pwr_mem_bit])
		begin
			// stored settings overwrite all working registers, no defaults loaded first
			power_up.work = d.nvm;
		end
		if (set[pwr_test_bit])
		begin
			power_up.test_reg = test_por;
		end
		// calibration can only be skipped once it has completed
		if (set[calibration_redo_bit] || !d.cal_valid)
		begin
			power_up.cal_valid = 1'b0;
			power_up.ctmr = 32'h0000_0000;
			power_up.pw = pw_cal;
		end
		else
		begin
			power_up.pw = pw_on;
		end
	endfunction

	// ------------------------------------------------------------
	// pin sampling
	// ------------------------------------------------------------
	assign scl_rise = r.s2[0] & ~r.s3[0];
	assign scl_fall = ~r.s2[0] & r.s3[0];
	assign sda_in = r.s2[1];
	assign start_seen = r.s2[0] & r.s3[0] & r.s3[1] & ~r.s2[1];
	assign stop_seen = r.s2[0] & r.s3[0] & ~r.s3[1] & r.s2[1];
	assign rx_byte = {r.sh[6:0], sda_in};

	always_comb
	begin
		next_r = r;
		next_r.s1 = {en_pin, bus.sda, bus.scl};
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		next_r.rdata = r.work[user_raddr];
		if (test_wr)
		begin
			next_r.test_reg = test_wdata;
		end
		// ------------------------------------------------------------
		// byte engine
		// ------------------------------------------------------------
		if (start_seen)
		begin
			next_r.st = st_rx;
			next_r.cnt = 4'h0;
			next_r.bidx = 2'h0;
			next_r.oe_n = 1'b1;
		end
		else if (stop_seen)
		begin
			next_r.st = st_idle;
			next_r.oe_n = 1'b1;
			next_r.wr_go = 1'b0;
			next_r.rd_go = 1'b0;
		end
		else
		begin
			case (r.st)
				st_rx:
				begin
					if (scl_rise)
					begin
						next_r.sh = rx_byte;
						next_r.cnt = r.cnt + 4'h1;
						if (r.cnt == 4'h7)
						begin
							next_r.st = st_rx_ack;
							next_r.phase = 1'b0;
							next_r.ack = 1'b0;
							if (r.bidx != 2'h3)
							begin
								next_r.bidx = r.bidx + 2'h1;
							end
							case (r.bidx)
								2'h0:
								begin
									next_r.rw = rx_byte[0];
									if (rx_byte[7:1] != dev_addr)
									begin
										next_r.st = st_idle;
									end
									else
									begin
										next_r.ack = ~rx_byte[0] | r.rd_go;
									end
								end
								2'h1:
								begin
									next_r.cmd = rx_byte;
									next_r.wr_go = 1'b0;
									next_r.rd_go = 1'b0;
									if (!r.prog)
									begin
										case (rx_byte)
											reg_read_cmd, reg_write_cmd, power_cmd:
											begin
												next_r.ack = 1'b1;
											end
											stored_settings_reload_cmd:
											begin
												next_r.ack = 1'b1;
												next_r.work = r.nvm;
											end
											stored_settings_program_cmd:
											begin
												next_r.ack = 1'b1;
												next_r.nvm = r.work;
												next_r.prog = 1'b1;
												next_r.tmr = 32'h0000_0000;
											end
											default:
											begin
												next_r.ack = 1'b0;
											end
										endcase
									end
								end
								2'h2:
								begin
									next_r.ptr = {1'b0, rx_byte[3:0]};
									if (r.cmd == reg_read_cmd)
									begin
										next_r.rd_go = (rx_byte[7:4] == 4'h0) &&
											rd_mask[rx_byte[3:0]];
										next_r.ack = next_r.rd_go;
									end
									else if (r.cmd == reg_write_cmd)
									begin
										next_r.wr_go = (rx_byte[7:4] == 4'h0) &&
											wr_mask[rx_byte[3:0]];
										next_r.ack = next_r.wr_go;
									end
									else if (r.cmd == power_cmd)
									begin
										next_r.ack = (rx_byte[7:5] == 3'h0);
										if (next_r.ack && !rx_byte[pwr_en_bit])
										begin
											// without the restart bit, registers and calibration stay intact
											next_r.pw = pw_dis;
											if (rx_byte[pwr_restart_bit])
											begin
												next_r = power_up(next_r, rx_byte);
											end
										end
										else if (next_r.ack && r.pw == pw_dis)
										begin
											next_r = power_up(next_r, rx_byte);
										end
									end
								end
								default:
								begin
									if (r.wr_go && !r.ptr[4])
									begin
										next_r.ack = 1'b1;
										if (wr_mask[r.ptr[3:0]])
										begin
											next_r.work[r.ptr[3:0]] = rx_byte;
										end
										next_r.ptr = r.ptr + 5'h01;
									end
									else
									begin
										next_r.ack = 1'b0;
									end
								end
							endcase
						end
					end
				end
				st_rx_ack:
				begin
					if (scl_fall && !r.phase)
					begin
						next_r.oe_n = ~r.ack;
						next_r.phase = 1'b1;
					end
					else if (scl_fall)
					begin
						next_r.cnt = 4'h0;
						next_r.oe_n = 1'b1;
						next_r.st = st_rx;
						if (r.rw && r.ack)
						begin
							next_r.tx = rd_byte(r.work, r.ptr);
							next_r.oe_n = next_r.tx[7];
							next_r.st = st_tx;
						end
					end
				end
				st_tx:
				begin
					if (scl_rise)
					begin
						next_r.cnt = r.cnt + 4'h1;
					end
					else if (scl_fall && r.cnt == 4'h8)
					begin
						next_r.oe_n = 1'b1;
						next_r.st = st_tx_ack;
						next_r.phase = 1'b0;
					end
					else if (scl_fall)
					begin
						next_r.oe_n = r.tx[6];
						next_r.tx = {r.tx[6:0], 1'b0};
					end
				end
				st_tx_ack:
				begin
					if (scl_rise && sda_in)
					begin
						next_r.st = st_idle;
					end
					else if (scl_rise)
					begin
						next_r.phase = 1'b1;
						if (!r.ptr[4])
						begin
							next_r.ptr = r.ptr + 5'h01;
						end
					end
					else if (scl_fall && r.phase)
					begin
						next_r.tx = rd_byte(r.work, r.ptr);
						next_r.oe_n = next_r.tx[7];
						next_r.cnt = 4'h0;
						next_r.st = st_tx;
					end
				end
				default:
				begin
					next_r.oe_n = 1'b1;
				end
			endcase
		end
		// ------------------------------------------------------------
		// timed sequences
		// ------------------------------------------------------------
		if (r.prog)
		begin
			next_r.tmr = r.tmr + 32'h0000_0001;
			if (r.tmr == PROG_CYC - 1)
			begin
				next_r.prog = 1'b0;
			end
		end
		if (r.pw == pw_cal)
		begin
			next_r.ctmr = r.ctmr + 32'h0000_0001;
			if (r.ctmr == CAL_CYC - 1)
			begin
				next_r.cal_valid = 1'b1;
				next_r.pw = pw_on;
			end
		end
		// ------------------------------------------------------------
		// physical enable overrides power state, working and test registers, calibration and program busy
		// ------------------------------------------------------------
		if (!r.s2[2])
		begin
			for (int i = 0; i < 16; i++)
			begin
				next_r.work[i] = work_por;
			end
			next_r.test_reg = test_por;
			next_r.cal_valid = 1'b0;
			next_r.prog = 1'b0;
			next_r.pw = pw_dis;
		end
		else if (!r.s3[2])
		begin
			next_r = power_up(next_r, pwr_full);
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			r <= '0;
			r.st <= st_idle;
			r.pw <= pw_dis;
			r.oe_n <= 1'b1;
			r.s1 <= 3'h3;
			r.s2 <= 3'h3;
			r.s3 <= 3'h3;
			for (int i = 0; i < 16; i++)
			begin
				r.work[i] <= work_por;
				r.nvm[i] <= nvm_init;
			end
		end
		else
		begin
			r <= next_r;
		end
	end

	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_sda_oe_n = r.oe_n;
	assign user_rdata = r.rdata;
	assign test_reg = r.test_reg;
	assign operating = (r.pw == pw_on);
	assign cal_valid = r.cal_valid;
	assign busy = r.prog;
endmodule // i2cui_dev
`default_nettype wire

// ---- i2cui_pkg.sv ----
// shared constants and types of the i2c user command interpreter
package i2cui_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned clk_mhz = 250;
	localparam int unsigned prog_typ_ms = 380;
	localparam int unsigned prog_cyc = prog_typ_ms * 1000 * clk_mhz;
	localparam int unsigned cal_ms = 2;
	localparam int unsigned cal_cyc = cal_ms * 1000 * clk_mhz;
	localparam logic [4:0] scl_quarter = 5'h19;
	// ------------------------------------------------------------
	// bus address and commands
	// ------------------------------------------------------------
	localparam logic [6:0] dev_addr = 7'h2a;
	localparam logic [7:0] reg_read_cmd = 8'h10;
	localparam logic [7:0] reg_write_cmd = 8'h11;
	localparam logic [7:0] stored_settings_reload_cmd = 8'h12;
	localparam logic [7:0] stored_settings_program_cmd = 8'h13;
	localparam logic [7:0] power_cmd = 8'h14;
	// ------------------------------------------------------------
	// user register range, access maps, reset values
	// ------------------------------------------------------------
	localparam logic [15:0] rd_mask = 16'hfff7;
	localparam logic [15:0] wr_mask = 16'h2ff3;
	localparam logic [7:0] work_por = 8'h00;
	localparam logic [7:0] nvm_init = 8'h00;
	localparam logic [7:0] test_por = 8'h00;
	// ------------------------------------------------------------
	// power setting byte fields
	// ------------------------------------------------------------
	localparam int unsigned pwr_en_bit = 0;
	localparam int unsigned pwr_restart_bit = 1;
	localparam int unsigned calibration_redo_bit = 2;
	localparam int unsigned pwr_mem_bit = 3;
	localparam int unsigned pwr_test_bit = 4;
	localparam logic [7:0] pwr_full = 8'h1e;
	// ------------------------------------------------------------
	// host apb registers and operations
	// ------------------------------------------------------------
	localparam logic [7:0] reg_cmd = 8'h00;
	localparam logic [7:0] reg_arg = 8'h04;
	localparam logic [7:0] reg_wdata = 8'h08;
	localparam logic [7:0] reg_rdata = 8'h0c;
	localparam logic [7:0] reg_status = 8'h10;
	typedef enum logic [2:0] {
		op_none = 3'b000,
		op_read = 3'b001,
		op_write = 3'b010,
		op_reload = 3'b011,
		op_program = 3'b100,
		op_power = 3'b101
	} i2cui_op_t;
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_rx = 3'b001,
		st_rx_ack = 3'b010,
		st_tx = 3'b011,
		st_tx_ack = 3'b100
	} i2cui_dst_t;
	typedef enum logic [1:0] {
		pw_dis = 2'b00,
		pw_cal = 2'b01,
		pw_on = 2'b10
	} i2cui_pw_t;
	typedef enum logic [1:0] {
		m_idle = 2'b00,
		m_start = 2'b01,
		m_bit = 2'b10,
		m_stop = 2'b11
	} i2cui_mst_t;
endpackage

// ---- i2cui_if.sv ----
// two-wire link between host and device ends
`timescale 1ns/1ns
`default_nettype none
interface i2cui_if;
	logic scl;
	logic sda;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	// wired-and: a driver pulls the line only while its enable is low
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
	modport host (output scl, output host_sda_o, output host_sda_oe_n,
		input sda);
	modport dev (input scl, input sda, output dev_sda_o,
		output dev_sda_oe_n);
endinterface
`default_nettype wire

// ---- i2cui_host.sv ----
// host end: apb-controlled i2c master issuing user commands
`timescale 1ns/1ns
`default_nettype none
module i2cui_host (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link
	i2cui_if.host bus
);
	import i2cui_pkg::*;

	typedef struct packed {
		logic [31:0] prdata;
		i2cui_op_t op;
		logic [1:0] cnt;
		logic [7:0] arg;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic nack;
		logic busy;
		logic s1;
		logic s2;
		logic [4:0] div;
		logic [1:0] q;
		i2cui_mst_t m;
		logic [3:0] bit_i;
		logic [7:0] sh;
		logic ackbit;
		logic [2:0] pos;
		logic [1:0] stage;
		logic [1:0] rcnt;
		logic scl;
		logic oe_n;
	} i2cui_host_t;

	i2cui_host_t r;
	i2cui_host_t next_r;
	logic tick;
	logic [2:0] total;

	function automatic logic [7:0] tx_byte(input i2cui_host_t d,
		input logic [2:0] p);
		case (p)
			3'h0: tx_byte = {dev_addr, 1'b0};
			3'h1:
			begin
				case (d.op)
					op_read: tx_byte = reg_read_cmd;
					op_write: tx_byte = reg_write_cmd;
					op_reload: tx_byte = stored_settings_reload_cmd;
					op_program: tx_byte = stored_settings_program_cmd;
					default: tx_byte = power_cmd;
				endcase
			end
			3'h2: tx_byte = d.arg;
			default: tx_byte = d.wdata[8 * (p - 3'h3) +: 8];
		endcase
	endfunction

	assign tick = (r.div == scl_quarter - 5'h01);
	assign total = (r.op == op_reload || r.op == op_program) ? 3'h2 :
		(r.op == op_write) ? 3'h4 + {1'b0, r.cnt} : 3'h3;

	always_comb
	begin
		next_r = r;
		next_r.s1 = bus.sda;
		next_r.s2 = r.s1;
		// ------------------------------------------------------------
		// apb registers: read data captured in the setup cycle
		// ------------------------------------------------------------
		if (psel && !penable)
		begin
			case (paddr)
				reg_cmd: next_r.prdata = {22'h00_0000, r.cnt, 5'h00, r.op};
				reg_arg: next_r.prdata = {24'h00_0000, r.arg};
				reg_wdata: next_r.prdata = r.wdata;
				reg_rdata: next_r.prdata = r.rdata;
				reg_status: next_r.prdata = {30'h0000_0000, r.nack, r.busy};
				default: next_r.prdata = 32'h0000_0000;
			endcase
		end
		// writes to operand registers during a transfer are ignored
		if (psel && penable && pwrite && !r.busy)
		begin
			case (paddr)
				reg_cmd:
				begin
					if (pwdata[2:0] >= 3'h1 && pwdata[2:0] <= 3'h5)
					begin
						next_r.op = i2cui_op_t'(pwdata[2:0]);
						next_r.cnt = pwdata[9:8];
						next_r.busy = 1'b1;
						next_r.nack = 1'b0;
						next_r.m = m_start;
						next_r.stage = 2'h0;
						next_r.q = 2'h0;
						next_r.div = 5'h00;
					end
				end
				reg_arg: next_r.arg = pwdata[7:0];
				reg_wdata: next_r.wdata = pwdata;
				default:
				begin
				end
			endcase
		end
		// ------------------------------------------------------------
		// bit engine, one quarter of scl per tick
		// ------------------------------------------------------------
		if (r.m != m_idle)
		begin
			next_r.div = tick ? 5'h00 : r.div + 5'h01;
		end
		if (tick)
		begin
			next_r.q = r.q + 2'h1;
			case (r.m)
				m_start:
				begin
					case (r.q)
						2'h0: next_r.oe_n = 1'b1;
						2'h1: next_r.scl = 1'b1;
						2'h2: next_r.oe_n = 1'b0;
						default:
						begin
							next_r.scl = 1'b0;
							next_r.m = m_bit;
							next_r.bit_i = 4'h0;
							if (r.stage == 2'h1)
							begin
								next_r.sh = {dev_addr, 1'b1};
							end
							else
							begin
								next_r.pos = 3'h0;
								next_r.sh = tx_byte(r, 3'h0);
							end
						end
					endcase
				end
				m_bit:
				begin
					case (r.q)
						2'h0:
						begin
							if (r.stage == 2'h2)
							begin
								next_r.oe_n = (r.bit_i != 4'h8) || (r.rcnt == r.cnt);
							end
							else
							begin
								next_r.oe_n = (r.bit_i == 4'h8) || r.sh[7];
							end
						end
						2'h1: next_r.scl = 1'b1;
						2'h2:
						begin
							if (r.bit_i == 4'h8)
							begin
								next_r.ackbit = r.s2;
							end
							else
							begin
								next_r.sh = {r.sh[6:0], r.s2};
							end
						end
						default:
						begin
							next_r.scl = 1'b0;
							next_r.bit_i = r.bit_i + 4'h1;
							if (r.bit_i == 4'h8)
							begin
								next_r.bit_i = 4'h0;
								if (r.stage == 2'h2)
								begin
									next_r.rdata[8 * r.rcnt +: 8] = r.sh;
									next_r.rcnt = r.rcnt + 2'h1;
									if (r.rcnt == r.cnt)
									begin
										next_r.m = m_stop;
									end
								end
								else if (r.ackbit)
								begin
									next_r.nack = 1'b1;
									next_r.m = m_stop;
								end
								else if (r.stage == 2'h1)
								begin
									next_r.stage = 2'h2;
									next_r.rcnt = 2'h0;
								end
								else if (r.pos + 3'h1 < total)
								begin
									next_r.pos = r.pos + 3'h1;
									next_r.sh = tx_byte(r, r.pos + 3'h1);
								end
								else if (r.op == op_read)
								begin
									// direction changes only through a repeated start
									next_r.stage = 2'h1;
									next_r.m = m_start;
								end
								else
								begin
									next_r.m = m_stop;
								end
							end
						end
					endcase
				end
				m_stop:
				begin
					case (r.q)
						2'h0: next_r.oe_n = 1'b0;
						2'h1: next_r.scl = 1'b1;
						2'h2: next_r.oe_n = 1'b1;
						default:
						begin
							next_r.m = m_idle;
							next_r.busy = 1'b0;
						end
					endcase
				end
				default:
				begin
					next_r.q = 2'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			r <= '0;
			r.op <= op_none;
			r.m <= m_idle;
			r.s1 <= 1'b1;
			r.s2 <= 1'b1;
			r.scl <= 1'b1;
			r.oe_n <= 1'b1;
		end
		else
		begin
			r <= next_r;
		end
	end

	assign prdata = r.prdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign bus.scl = r.scl;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe_n = r.oe_n;
endmodule // i2cui_host
`default_nettype wire

// ---- i2cui_chk.sv ----
// wire-level checks on the two-wire user command link
`timescale 1ns/1ns
`default_nettype none
module i2cui_chk (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// link
	input wire logic scl,
	input wire logic sda,
	input wire logic host_sda_o,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (srst);
	// ------
	// properties
	// ------
	// data must hold steady for the 8 cycles after scl rises
	property p_sda_hold;
		$rose(scl) |=> $stable(sda) [*8];
	endproperty
	a_sda_hold: assert property (p_sda_hold)
		else $error("sda moved right after scl rise");
	// open drain: neither end may drive the line high
	property p_sda_fall;
		$fell(scl) |-> $stable(sda) && !host_sda_o && !dev_sda_o;
	endproperty
	a_sda_fall: assert property (p_sda_fall)
		else $error("sda moved as scl fell");
	// a change with scl high would read as a start or stop
	property p_dev_edge;
		$changed(dev_sda_oe_n) |-> !scl;
	endproperty
	a_dev_edge: assert property (p_dev_edge)
		else $error("device moved sda with scl high");
	property p_dev_lag;
		$changed(dev_sda_oe_n) |-> !$past(scl) && !$past(scl, 2);
	endproperty
	a_dev_lag: assert property (p_dev_lag)
		else $error("device moved sda too soon after scl fall");
	property p_dev_quiet;
		$fell(scl) |=> $stable(dev_sda_oe_n);
	endproperty
	a_dev_quiet: assert property (p_dev_quiet)
		else $error("device sda not synchronised to scl");
	property p_scl_high;
		$rose(scl) |=> scl [*8];
	endproperty
	a_scl_high: assert property (p_scl_high)
		else $error("scl high phase too short");
	property p_scl_low;
		$fell(scl) |=> !scl [*8];
	endproperty
	a_scl_low: assert property (p_scl_low)
		else $error("scl low phase too short");
	property p_start_host;
		$fell(sda) && scl && $past(scl) |-> dev_sda_oe_n && !host_sda_oe_n;
	endproperty
	a_start_host: assert property (p_start_host)
		else $error("start not made by host");
	c_dev_ack: cover property ($fell(dev_sda_oe_n));
	c_start: cover property ($fell(sda) && scl && $past(scl));
	c_stop: cover property ($rose(sda) && scl);
endmodule // i2cui_chk
`default_nettype wire

// ---- i2c_user_command_interpreter_tb.sv ----
// self-checking bench for host and device ends across the link
`timescale 1ns/1ns
`default_nettype none
module i2c_user_command_interpreter_tb;
	import i2cui_pkg::*;
	// ------
	// signals and model state
	// ------
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic en_pin = 1'b0;
	logic test_wr = 1'b0;
	logic [7:0] test_wdata = 8'h00;
	logic [3:0] user_raddr = 4'h0;
	logic [7:0] user_rdata;
	logic [7:0] test_reg;
	logic operating;
	logic cal_valid;
	logic busy;
	int error_cnt = 0;
	int checked = 0;
	logic [7:0] wk [16];
	logic [7:0] st [16];
	logic [7:0] tr;
	logic om;
	logic bz;
	logic [31:0] r;
	logic [31:0] s;
	logic [7:0] pv [7] = '{8'h00, 8'h01, 8'h12, 8'h00, 8'h1a, 8'h06, 8'h20};
	i2cui_if bus_if ();
	i2cui_host i2cui_host_i (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(), .bus(bus_if.host));
	// short program and calibration times keep the run brief
	i2cui_dev #(.PROG_CYC(20), .CAL_CYC(10)) i2cui_dev_i (.clk(clk),
		.srst(srst), .bus(bus_if.dev), .en_pin(en_pin), .test_wr(test_wr),
		.test_wdata(test_wdata), .user_raddr(user_raddr),
		.user_rdata(user_rdata), .test_reg(test_reg), .operating(operating),
		.cal_valid(cal_valid), .busy(busy));
	i2cui_chk i2cui_chk_i (.clk(clk), .srst(srst), .scl(bus_if.scl),
		.sda(bus_if.sda), .host_sda_o(bus_if.host_sda_o),
		.host_sda_oe_n(bus_if.host_sda_oe_n), .dev_sda_o(bus_if.dev_sda_o),
		.dev_sda_oe_n(bus_if.dev_sda_oe_n));
	initial
	begin
		forever #2 clk = ~clk;
	end
	// ------
	// tasks
	// ------
	task automatic complete_run;
	begin
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
	begin
		checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	end
	endtask
	// idle cycle first, so psel never gets two values in one step
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
	begin
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	task automatic cmd(input i2cui_op_t op, input int n, input int a,
		input logic [31:0] d);
	begin
		apb(1'b1, reg_arg, 32'(a));
		apb(1'b1, reg_wdata, d);
		apb(1'b1, reg_cmd, 32'({2'(n - 1), 5'h00, op}));
		bz = 1'b0;
		do
		begin
			apb(1'b0, reg_status, 32'h0);
			bz = bz | busy;
		end
		while (r[0] !== 1'b0);
		s = r;
	end
	endtask
	task automatic chk_work;
	begin
		for (int i = 0; i < 16; i++)
		begin
			user_raddr <= 4'(i);
			repeat (3) @(posedge clk);
			chk(user_rdata, wk[i]);
		end
		chk(test_reg, tr);
	end
	endtask
	task automatic rd(input int a, input int n);
	begin
		cmd(op_read, n, a, 32'h0);
		chk(s[1], !rd_mask[a]);
		if (rd_mask[a])
		begin
			apb(1'b0, reg_rdata, 32'h0);
			for (int k = 0; k < n; k++)
				chk(r[8 * k +: 8], (a + k < 16 && rd_mask[a + k]) ?
					wk[a + k] : 8'h00);
		end
	end
	endtask
	task automatic wrt(input int a, input int n, input logic [31:0] d);
	begin
		cmd(op_write, n, a, d);
		chk(s[1], !wr_mask[a] || a + n > 16);
		for (int k = 0; k < n; k++)
			if (wr_mask[a] && a + k < 16 && wr_mask[a + k])
				wk[a + k] = d[8 * k +: 8];
		chk_work();
	end
	endtask
	task automatic pwr(input logic [7:0] v);
		logic up;
	begin
		cmd(op_power, 1, int'(v), 32'h0);
		chk(s[1], v[7:5] != 3'b000);
		up = 1'b0;
		if (v[7:5] == 3'b000 && !v[0])
		begin
			om = 1'b0;
			up = v[1];
		end
		else if (v[7:5] == 3'b000 && !om)
			up = 1'b1;
		if (up)
		begin
			om = 1'b1;
			if (v[3])
				wk = st;
			if (v[4])
				tr = 8'h00;
		end
		repeat (40) @(posedge clk);
		chk(operating, om);
		chk(cal_valid, 1'b1);
		chk_work();
	end
	endtask
	// ------
	// tests
	// ------
	initial
	begin
		r = $urandom(48536);
		om = 1'b0;
		tr = 8'h00;
		for (int i = 0; i < 16; i++)
		begin
			wk[i] = 8'h00;
			st[i] = 8'h00;
		end
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		en_pin <= 1'b1;
		repeat (60) @(posedge clk);
		om = 1'b1;
		chk(operating, 1'b1);
		$display("test power-up done");
		wrt(0, 4, $urandom);
		rd(0, 4);
		wrt(2, 1, $urandom);
		rd(3, 1);
		wrt(13, 4, $urandom);
		rd(13, 4);
		$display("test block access done");
		cmd(op_program, 1, 0, 32'h0);
		chk(s[1], 1'b0);
		chk(bz, 1'b1);
		chk(busy, 1'b0);
		st = wk;
		wrt(4, 4, $urandom);
		cmd(op_reload, 1, 0, 32'h0);
		wk = st;
		chk_work();
		$display("test stored settings done");
		foreach (pv[i])
		begin
			@(posedge clk);
			tr = 8'($urandom);
			test_wr <= 1'b1;
			test_wdata <= tr;
			@(posedge clk);
			test_wr <= 1'b0;
			wrt(0, 1, $urandom);
			pwr(pv[i]);
		end
		$display("test power command done");
		en_pin <= 1'b0;
		repeat (10) @(posedge clk);
		for (int i = 0; i < 16; i++)
			wk[i] = 8'h00;
		tr = 8'h00;
		chk(operating, 1'b0);
		chk(cal_valid, 1'b0);
		chk_work();
		en_pin <= 1'b1;
		repeat (60) @(posedge clk);
		wk = st;
		chk(operating, 1'b1);
		chk_work();
		$display("test enable pin done");
		complete_run();
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		error_cnt++;
		complete_run();
	end
endmodule // i2c_user_command_interpreter_tb
`default_nettype wire
